// ===== rtl/gia_pkg.sv
`default_nettype none

package gia_pkg;

  // Port geometry
  localparam int unsigned PORT_W = 32;
  localparam int unsigned LANE_W = 8;
  localparam int unsigned LANE_N = PORT_W / LANE_W;

  // Pin function selection, one field per pin
  typedef enum logic [1:0] {
    GIA_MODE_GPIO,
    GIA_MODE_IRQ,
    GIA_MODE_DEDIC
  } gia_mode_e;

  // Pin positions with a fixed board role
  localparam int unsigned PIN_SERIAL_IRQ  = 0;
  localparam int unsigned PIN_WD_NMI_IN   = 6;
  localparam int unsigned PIN_WD_NMI_OUT  = 24;
  localparam int unsigned PIN_WD_EXPIRED  = 25;
  localparam int unsigned PIN_ROM_INIT    = 26;
  localparam int unsigned PIN_ARB_GRANT   = 29;

  // Interrupt polarity: a one marks an active-high input, all others are active low
  localparam logic [31:0] IRQ_ACT_HIGH_MASK = 32'h0000_0001;

  // Values after reset
  localparam logic [63:0] MODE_RST     = 64'h0000_0000_0000_0000;
  localparam logic [31:0] GPIO_OE_RST  = 32'h0000_0000;
  localparam logic [31:0] GPIO_OUT_RST = 32'h0000_0000;
  localparam logic [31:0] IRQ_EN_RST   = 32'h0000_0000;

  // Byte lane that owns a pin
  function automatic logic [1:0] lane_of(input int unsigned pin);
    lane_of = 2'(pin / LANE_W);
  endfunction

endpackage

`default_nettype wire

// ===== rtl/gia_lane_merge.sv
`default_nettype none

module gia_lane_merge
  import gia_pkg::*;
(
  input  wire logic [7:0] pin_lvl,  // Raw pin levels of one lane
  input  wire logic [7:0] irq_sel,  // Pin is an interrupt input
  input  wire logic [7:0] irq_en,   // Per-pin interrupt enable
  input  wire logic [7:0] act_high, // Per-pin polarity, one is active high
  output logic            req       // Lane request, pure level
);

  // Level sensing only: a request follows its pin with no latch, so it drops
  // when the cause clears at the source or its enable or interrupt mode is cleared
  always_comb begin
    req = |(irq_sel & irq_en & ~(pin_lvl ^ act_high));
  end

endmodule

`default_nettype wire

// ===== rtl/gia_port.sv
`default_nettype none

module gia_port
  import gia_pkg::*;
(
  input  wire logic              clk,                  // Core clock, 250 MHz
  input  wire logic              nrst,                 // Async reset, active low
  input  wire logic              cfg_load,             // Pulse: take the new configuration
  input  wire logic [63:0]       cfg_mode,             // Two-bit function per pin
  input  wire logic [31:0]       cfg_gpio_oe,          // GPIO direction, one drives
  input  wire logic [31:0]       cfg_gpio_out,         // GPIO output values
  input  wire logic [31:0]       cfg_irq_en,           // Per-pin interrupt enable
  input  wire logic              internal_irq,         // Combined internal unit requests
  input  wire logic              watchdog_nmi_in,      // Watchdog NMI, active high
  input  wire logic              watchdog_expired_in,  // Watchdog expiry, active high
  input  wire logic              rom_init_active,      // Serial-ROM load running
  input  wire logic              external_arbiter_grant, // Enable external arbiter grant
  input  wire logic [31:0]       multipurpose_port_pin_i,  // Pin levels
  output logic [31:0]            multipurpose_port_pin_o,  // Pin drive values
  output logic [31:0]            multipurpose_port_pin_oe, // Pin drive enables
  output logic [31:0]            pin_level,            // Registered pin levels for software
  output logic [3:0]             lane_irq,             // Merged lane sources
  output logic                   processor_irq_out_n   // Processor interrupt, active low
);

  // Configuration state
  logic [63:0] mode_q, mode_d;
  logic [31:0] gpio_oe_q, gpio_oe_d;
  logic [31:0] gpio_out_q, gpio_out_d;
  logic [31:0] irq_en_q, irq_en_d;

  // Pin and interrupt state
  logic [31:0] pin_o_q, pin_o_d;
  logic [31:0] pin_oe_q, pin_oe_d;
  logic [31:0] pin_lvl_q, pin_lvl_d;
  logic [3:0]  lane_q, lane_d;
  logic        irq_n_q, irq_n_d;

  // Per-pin interrupt role and per-lane raw requests
  logic [31:0] is_irq;
  logic [3:0]  lane_req;

  // Board roles of the 32 pins, for whoever loads the configuration; the block
  // itself only fixes the owners of 24, 25, 26 and 29 and the polarity of pin 0
  // Lane 0
  //   0  serial port requests, active high
  //   1  spare input, pulled high
  //   2  front panel abort switch
  //   3  clock alarm or temperature alarm
  //   4  spare, strapped to 27
  //   5  spare, strapped to 28
  //   6  watchdog NMI looped back from 24
  //   7  network transceiver
  // Lane 1
  //   8  first slot line A
  //   9  first slot line B
  //   10 first slot line C
  //   11 first slot line D
  //   12 bridge request 0
  //   13 bridge request 1
  //   14 bridge request 2
  //   15 bridge request 3
  // Lane 2
  //   16 second slot line A
  //   17 second slot line B
  //   18 second slot line C
  //   19 second slot line D
  //   20 gigabit controller
  //   21 spare input, pulled high
  //   22 spare input, pulled high
  //   23 spare input, pulled high
  // Lane 3
  //   24 watchdog NMI out, active low
  //   25 watchdog expired out, active low
  //   26 serial-ROM load running
  //   27 spare, strapped to 4
  //   28 spare output held high, strapped to 5
  //   29 external arbiter grant enable
  //   30 spare input, pulled high
  //   31 spare input, pulled high

  // Two-bit function field of one pin; shared by the interrupt decode and
  // the pin drive so both always agree on the field position
  function automatic gia_mode_e mode_of(input logic [63:0] modes, input int pin);
    mode_of = gia_mode_e'(modes[2*pin +: 2]);
  endfunction

  // Decoded per-pin roles
  always_comb begin
    for (int i = 0; i < int'(PORT_W); i++) begin
      is_irq[i] = mode_of(mode_q, i) == GIA_MODE_IRQ;
    end
  end

  // One merge per byte lane; pin n lands in lane n/8
  for (genvar g = 0; g < int'(LANE_N); g++) begin : g_lane
    gia_lane_merge u_merge (
      .pin_lvl  (multipurpose_port_pin_i[g*LANE_W +: LANE_W]),
      .irq_sel  (is_irq[g*LANE_W +: LANE_W]),
      .irq_en   (irq_en_q[g*LANE_W +: LANE_W]),
      .act_high (IRQ_ACT_HIGH_MASK[g*LANE_W +: LANE_W]),
      .req      (lane_req[g])
    );
  end

  // Configuration changes only on a software load; reset gives all GPIO inputs
  always_comb begin
    mode_d     = mode_q;
    gpio_oe_d  = gpio_oe_q;
    gpio_out_d = gpio_out_q;
    irq_en_d   = irq_en_q;
    if (cfg_load) begin
      mode_d     = cfg_mode;
      gpio_oe_d  = cfg_gpio_oe;
      gpio_out_d = cfg_gpio_out;
      irq_en_d   = cfg_irq_en;
    end
  end

  // Configuration registers; reset leaves every pin an undriven GPIO input
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q     <= MODE_RST;
      gpio_oe_q  <= GPIO_OE_RST;
      gpio_out_q <= GPIO_OUT_RST;
      irq_en_q   <= IRQ_EN_RST;
    end else begin
      mode_q     <= mode_d;
      gpio_oe_q  <= gpio_oe_d;
      gpio_out_q <= gpio_out_d;
      irq_en_q   <= irq_en_d;
    end
  end

  // Pin drive: GPIO follows its direction bit, interrupt pins never drive,
  // dedicated pins drive only where an internal unit owns an output
  always_comb begin
    pin_o_d  = 32'h0000_0000;
    pin_oe_d = 32'h0000_0000;
    for (int i = 0; i < int'(PORT_W); i++) begin
      case (mode_of(mode_q, i))
        GIA_MODE_GPIO: begin
          pin_o_d[i]  = gpio_out_q[i];
          pin_oe_d[i] = gpio_oe_q[i];
        end
        GIA_MODE_IRQ: begin
          pin_oe_d[i] = 1'b0;
        end
        GIA_MODE_DEDIC: begin
          // Dedicated pins without an owner stay inputs rather than float a guess
          if (i == int'(PIN_WD_NMI_OUT)) begin
            pin_o_d[i]  = ~watchdog_nmi_in;
            pin_oe_d[i] = 1'b1;
          end else if (i == int'(PIN_WD_EXPIRED)) begin
            pin_o_d[i]  = ~watchdog_expired_in;
            pin_oe_d[i] = 1'b1;
          end else if (i == int'(PIN_ROM_INIT)) begin
            pin_o_d[i]  = rom_init_active;
            pin_oe_d[i] = 1'b1;
          end else if (i == int'(PIN_ARB_GRANT)) begin
            pin_o_d[i]  = external_arbiter_grant;
            pin_oe_d[i] = 1'b1;
          end
        end
        default: begin
          pin_oe_d[i] = 1'b0;
        end
      endcase
    end
  end

  // Lane sources and the single processor request; one register stage keeps
  // outputs glitch free at the cost of one cycle of latency
  always_comb begin
    pin_lvl_d = multipurpose_port_pin_i;
    lane_d    = lane_req;
    irq_n_d   = ~((|lane_req) | internal_irq);
  end

  // Output registers; reset releases every pin and drops all requests
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_o_q   <= 32'h0000_0000;
      pin_oe_q  <= 32'h0000_0000;
      pin_lvl_q <= 32'h0000_0000;
      lane_q    <= 4'h0;
      irq_n_q   <= 1'b1;
    end else begin
      pin_o_q   <= pin_o_d;
      pin_oe_q  <= pin_oe_d;
      pin_lvl_q <= pin_lvl_d;
      lane_q    <= lane_d;
      irq_n_q   <= irq_n_d;
    end
  end

  // Every output is a register, passed straight out
  assign multipurpose_port_pin_o  = pin_o_q;
  assign multipurpose_port_pin_oe = pin_oe_q;
  assign pin_level                = pin_lvl_q;
  assign lane_irq                 = lane_q;
  assign processor_irq_out_n      = irq_n_q;

endmodule

`default_nettype wire

// ===== tb/gia_port_asserts.sv
`default_nettype none
module gia_port_chk
  import gia_pkg::*;
(
  input wire logic        clk,                      // Clock
  input wire logic        nrst,                     // Reset
  input wire logic        cfg_load,                 // Load
  input wire logic [63:0] cfg_mode,                 // Modes
  input wire logic [31:0] cfg_gpio_oe,              // Directions
  input wire logic [31:0] cfg_gpio_out,             // Drive values
  input wire logic [31:0] cfg_irq_en,               // Enables
  input wire logic        internal_irq,             // Internal
  input wire logic        watchdog_nmi_in,          // NMI
  input wire logic        watchdog_expired_in,      // Expiry
  input wire logic        rom_init_active,          // ROM load
  input wire logic        external_arbiter_grant,   // Grant
  input wire logic [31:0] multipurpose_port_pin_i,  // Levels
  input wire logic [31:0] multipurpose_port_pin_o,  // Drives
  input wire logic [31:0] multipurpose_port_pin_oe, // Enables
  input wire logic [31:0] pin_level,                // Registered levels
  input wire logic [3:0]  lane_irq,                 // Lanes
  input wire logic        processor_irq_out_n       // Irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] m_q;
  logic [31:0] g_q, e_q, o_q, a, gm, go;
  logic [3:0]  l;
  logic        c;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Shadow of the loaded setup, so outputs can be predicted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {m_q, g_q, e_q, o_q} <= '0;
    end else if (cfg_load) begin
      {m_q, g_q, e_q, o_q} <= {cfg_mode, cfg_gpio_oe, cfg_irq_en, cfg_gpio_out};
    end
  end
  // Active inputs, their lane merge and the GPIO direction view
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      a[i] = m_q[2*i+:2] == 2'h1 && e_q[i]
        && multipurpose_port_pin_i[i] == IRQ_ACT_HIGH_MASK[i];
      gm[i] = m_q[2*i+:2] == 2'h0;
    end
    for (int n = 0; n < 4; n++) begin
      l[n] = |a[8*n+:8];
    end
    c = |l | internal_irq;
    go = gm & g_q;
  end
  AST_LANE: assert property (1'b1 |=> lane_irq == $past(l))
    else $error("lane source wrong");
  AST_CPU: assert property (1'b1 |=> processor_irq_out_n == !$past(c))
    else $error("processor irq wrong");
  AST_NMI: assert property (m_q[49:48] == 2'h2 |=> multipurpose_port_pin_oe[24]
    && multipurpose_port_pin_o[24] == !$past(watchdog_nmi_in)) else $error("nmi pin wrong");
  AST_EXP: assert property (m_q[51:50] == 2'h2 |=> multipurpose_port_pin_oe[25]
    && multipurpose_port_pin_o[25] == !$past(watchdog_expired_in)) else $error("expiry wrong");
  AST_ROM: assert property (m_q[53:52] == 2'h2 |=> multipurpose_port_pin_oe[26]
    && multipurpose_port_pin_o[26] == $past(rom_init_active)) else $error("rom pin wrong");
  AST_ARB: assert property (m_q[59:58] == 2'h2 |=> multipurpose_port_pin_oe[29]
    && multipurpose_port_pin_o[29] == $past(external_arbiter_grant)) else $error("grant wrong");
  AST_GPIO: assert property (1'b1 |=>
    (multipurpose_port_pin_oe & $past(gm)) == $past(go)) else $error("gpio direction wrong");
  AST_GOUT: assert property (1'b1 |=>
    (multipurpose_port_pin_o & $past(gm)) == $past(gm & o_q)) else $error("gpio value wrong");
  AST_LVL: assert property (1'b1 |=> pin_level == $past(multipurpose_port_pin_i))
    else $error("pin level wrong");
  AST_RST: assert property (!$past(nrst) |-> multipurpose_port_pin_oe == 32'h0)
    else $error("pin driven after reset");
endmodule
bind gia_port gia_port_chk chk_u (.clk, .nrst, .cfg_load, .cfg_mode, .cfg_gpio_oe,
  .cfg_gpio_out, .cfg_irq_en, .internal_irq, .watchdog_nmi_in, .watchdog_expired_in,
  .rom_init_active, .external_arbiter_grant, .multipurpose_port_pin_i,
  .multipurpose_port_pin_o, .multipurpose_port_pin_oe, .pin_level, .lane_irq,
  .processor_irq_out_n);
`default_nettype wire

// ===== tb/gia_board.sv
`default_nettype none
module gia_board (
  input  wire logic [31:0] pin_o,  // Drives
  input  wire logic [31:0] pin_oe, // Enables
  input  wire logic [31:0] src,    // Board sources
  input  wire logic [1:0]  alarm,  // Clock, thermostat
  output logic      [31:0] pin_i   // Levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] w;
  // Drivers override board sources, strapped pairs are wired-AND; a released pin never keeps a stale level
  always_comb begin
    w = (pin_o & pin_oe) | (src & ~pin_oe);
    pin_i = w;
    pin_i[3] = w[3] & ~|alarm;
    pin_i[6] = w[6] & w[24];
    pin_i[4] = w[4] & w[27];
    pin_i[27] = pin_i[4];
    pin_i[5] = w[5] & w[28];
    pin_i[28] = pin_i[5];
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, cfg_load = 1'b0, intr = 1'b0, nmi = 1'b0, wexp = 1'b0;
  logic rom = 1'b0, grant = 1'b0, irq_n;
  logic [63:0] mode = 64'h0;
  logic [31:0] oe = 32'h0, out = 32'h0, en = 32'h0, src = 32'hFFFF_FFFE, pin_i, pin_o, pin_oe;
  logic [1:0]  alarm = 2'h0;
  logic [3:0]  lane;
  logic [31:0] lvl;
  int fail_count = 0, checks_done = 0, cyc = 0;
  // Rows: board sources, internal, nmi, alarms, then expected lanes and irq
  logic [40:0] rows [9] = '{{32'hFFFF_FFFE, 4'h0, 5'h01}, {32'hFFFF_FFFF, 4'h0, 5'h02},
    {32'hFFFF_FCFE, 4'h0, 5'h04}, {32'hFFFF_FDFE, 4'h0, 5'h04}, {32'hFFF0_FFFE, 4'h0, 5'h08},
    {32'h7FFF_FFFE, 4'h0, 5'h10}, {32'hFFFF_FFFE, 4'h8, 5'h00}, {32'hFFFF_FFFE, 4'h4, 5'h02},
    {32'hFFFF_FFFE, 4'h1, 5'h02}};
  gia_port dut_u (.clk, .nrst, .cfg_load, .cfg_mode(mode), .cfg_gpio_oe(oe), .cfg_gpio_out(out),
    .cfg_irq_en(en), .internal_irq(intr), .watchdog_nmi_in(nmi), .watchdog_expired_in(wexp),
    .rom_init_active(rom), .external_arbiter_grant(grant), .multipurpose_port_pin_i(pin_i),
    .multipurpose_port_pin_o(pin_o), .multipurpose_port_pin_oe(pin_oe), .pin_level(lvl),
    .lane_irq(lane), .processor_irq_out_n(irq_n));
  gia_board board_u (.pin_o, .pin_oe, .src, .alarm, .pin_i);
  always #2 clk = ~clk;
  // Hang guard, far above the fewer than a hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One configuration load: strobe for one edge, then let the outputs settle
  task automatic load(input logic [63:0] m, input logic [31:0] o, input logic [31:0] v,
                      input logic [31:0] e);
    @(negedge clk);
    mode = m;
    oe = o;
    out = v;
    en = e;
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk(pin_oe, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    $display("reset test done");
    // Board map: 24-26 and 29 dedicated, 28 drives high, the rest interrupt inputs
    load(64'h586A_5555_5555_5555, 32'h1000_0000, 32'h1000_0000, 32'hFFFF_FFFF);
    chk(pin_oe, 32'h3700_0000);
    foreach (rows[k]) begin
      {src, intr, nmi, alarm} = rows[k][40:5];
      repeat (3) @(negedge clk);
      chk({28'h0, lane}, {28'h0, rows[k][4:1]});
      chk({31'h0, irq_n}, {31'h0, rows[k][0]});
      chk(lvl, pin_i);
    end
    $display("row tests done");
    wexp = 1'b1;
    rom = 1'b1;
    grant = 1'b1;
    repeat (2) @(negedge clk);
    chk(pin_o & 32'h3700_0000, 32'h3500_0000);
    // Expiry, ROM load and grant drop back and NMI rises; the loop-back NMI alone raises lane 0
    {nmi, wexp, rom, grant, alarm} = 6'h20;
    repeat (3) @(negedge clk);
    chk(pin_o & 32'h3700_0000, 32'h1200_0000);
    chk({28'h0, lane}, 32'h1);
    nmi = 1'b0;
    src = 32'hFFFF_FEFE;
    load(64'h586A_5555_5555_5555, 32'h1000_0000, 32'h1000_0000, 32'h0);
    chk({28'h0, lane}, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    // Mode 3 on pin 0 and an ownerless dedicated pin 1 neither drive nor request
    src = 32'hFFFF_FFFF;
    load(64'h586A_5555_5555_555B, 32'h1000_0000, 32'h1000_0000, 32'hFFFF_FFFF);
    chk(pin_oe, 32'h3700_0000);
    chk({28'h0, lane}, 32'h0);
    // All GPIO: direction and value come from separate words
    load(64'h0, 32'h0000_00F0, 32'h0000_0030, 32'hFFFF_FFFF);
    chk(pin_oe, 32'h0000_00F0);
    chk(pin_o, 32'h0000_0030);
    $display("dedicated and configuration tests done");
    // Reset in mid-run overrides a live internal request and clears the setup
    intr = 1'b1;
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk(pin_oe, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    nrst = 1'b1;
    intr = 1'b0;
    @(negedge clk);
    chk(pin_oe | pin_o, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
